// File: logic/hbw_front.sv
// host bus width detect, wide selects, address latch and wait-state timer
// Behaviour
// R01: detect input low after reset, before first config write, selects 16-bit mode.
// R02: no low seen in that window leaves 8-bit mode.
// R03: width bit shows detected default without any software write.
// R04: config write replaces default; later detect levels are ignored.
// R05: detect input has weak pull-up; open pin reads high, 8-bit.
// R06: board drives detect low only when a 16-bit bus is present.
// R07: memory wide select compares unlatched upper address, independent of latch enable.
// R08: I/O wide select compares unlatched I/O address directly.
// R09: I/O wide select asserted only while address matches and AEN low.
// R10: addresses still latched internally and latched copy used for access.
// R11: address captured on falling edge of memory read and write strobes.
// R12: board holds latch enable high in 8-bit mode.
// R13: each half of a split transfer uses its own strobe-edge address.
// R14: wait state holds ready negated two to three crystal clocks.
// R15: ready negation length same for every internal cycle type.
// R16: detect input synchronised; sticky low-seen flag until first config write.
`timescale 1ns/1ps
module hbw_front
  import hbw_pkg::*;
#(
  parameter logic [8:0] MEM_BASE = MEM_BASE_RST,
  parameter logic [13:0] IO_BASE = IO_BASE_RST
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic BUS_WIDTH_DETECT_N,
  input wire logic CFG_WRITE,
  input wire logic CFG_WIDTH_IN,
  input wire logic WAIT_ENABLE,
  input wire logic ACCESS_START,
  input wire logic [hbw_pkg::MEM_AW-1:0] SA,
  input wire logic AEN,
  input wire logic BALE,
  input wire logic MEM_READ_STROBE_N,
  input wire logic MEM_WRITE_STROBE_N,
  output logic WIDE_MODE,
  output logic MEM_WIDE_SELECT_N,
  output logic IO_WIDE_SELECT_N,
  output logic IOCHRDY,
  output hbw_pkg::hbw_mem_acc_t LATCHED_ACCESS
);
  import hbw_pkg::*;

  // R05 R06 pull-up lives in the pad; open pin arrives high
  logic det_s1_r, det_s2_r;
  logic rd_s1_r, rd_s2_r, wr_s1_r, wr_s2_r;
  logic rd_d_r, wr_d_r;
  // address must settle before the strobe; both see the same sync delay
  logic [MEM_AW-1:0] a_s1_r, a_s2_r;
  logic aen_s1_r, aen_s2_r, bale_s1_r, bale_s2_r;

  // R16 two-flop synchronisers for detect, strobe, address, aen and bale pins
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      det_s1_r <= 1'b1;
      det_s2_r <= 1'b1;
      rd_s1_r <= 1'b1;
      rd_s2_r <= 1'b1;
      wr_s1_r <= 1'b1;
      wr_s2_r <= 1'b1;
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b1;
      a_s1_r <= '0;
      a_s2_r <= '0;
      aen_s1_r <= 1'b1;
      aen_s2_r <= 1'b1;
      bale_s1_r <= 1'b1;
      bale_s2_r <= 1'b1;
    end else begin
      det_s1_r <= BUS_WIDTH_DETECT_N;
      det_s2_r <= det_s1_r;
      rd_s1_r <= MEM_READ_STROBE_N;
      rd_s2_r <= rd_s1_r;
      wr_s1_r <= MEM_WRITE_STROBE_N;
      wr_s2_r <= wr_s1_r;
      rd_d_r <= rd_s2_r;
      wr_d_r <= wr_s2_r;
      a_s1_r <= SA;
      a_s2_r <= a_s1_r;
      aen_s1_r <= AEN;
      aen_s2_r <= aen_s1_r;
      bale_s1_r <= BALE;
      bale_s2_r <= bale_s1_r;
    end
  end

  // width mode: sticky low-seen until the first config write
  logic cfg_written_r, cfg_written_nxt;
  logic wide_r, wide_nxt;
  always_comb begin
    cfg_written_nxt = cfg_written_r;
    wide_nxt = wide_r;
    // write beats a detect low in the same cycle
    if (CFG_WRITE) begin
      // R04 software override sticks
      cfg_written_nxt = 1'b1;
      wide_nxt = CFG_WIDTH_IN;
    end else if (!cfg_written_r && !det_s2_r) begin
      // R01 R03 R16 low seen sets 16-bit default
      wide_nxt = 1'b1;
    end
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      // R02 default 8-bit until a low is seen
      cfg_written_r <= 1'b0;
      wide_r <= 1'b0;
    end else begin
      cfg_written_r <= cfg_written_nxt;
      wide_r <= wide_nxt;
    end
  end

  // wide selects from the unlatched address; bale not consulted
  logic memcs_r, memcs_nxt, iocs_r, iocs_nxt;
  always_comb begin
    // R07 memory decode on live address
    memcs_nxt = !(a_s2_r[MEM_HI:MEM_LO] == MEM_BASE);
    // R08 R09 io decode qualified by aen low
    iocs_nxt = !((a_s2_r[IO_HI:IO_LO] == IO_BASE) && !aen_s2_r);
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      memcs_r <= 1'b1;
      iocs_r <= 1'b1;
    end else begin
      memcs_r <= memcs_nxt;
      iocs_r <= iocs_nxt;
    end
  end

  // address latch on strobe leading edge; bale ignored on purpose
  hbw_mem_acc_t lat_r, lat_nxt;
  logic rd_fall, wr_fall;
  always_comb begin
    rd_fall = rd_d_r && !rd_s2_r;
    wr_fall = wr_d_r && !wr_s2_r;
    lat_nxt = lat_r;
    lat_nxt.rd = 1'b0;
    lat_nxt.wr = 1'b0;
    // R10 R11 R13 each strobe edge takes its own address
    if (rd_fall || wr_fall) begin
      lat_nxt.addr = a_s2_r;
      lat_nxt.rd = rd_fall;
      lat_nxt.wr = wr_fall;
    end
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      lat_r <= '0;
    end else begin
      lat_r <= lat_nxt;
    end
  end

  // wait-state timer, one length for every cycle type
  hbw_wait_t ws_r, ws_nxt;
  logic [1:0] wcnt_r, wcnt_nxt;
  logic rdy_r, rdy_nxt;
  always_comb begin
    ws_nxt = ws_r;
    wcnt_nxt = wcnt_r;
    rdy_nxt = rdy_r;
    unique case (ws_r)
      W_IDLE: begin
        rdy_nxt = 1'b1;
        // R14 R15 same load for ram, register and prom cycles
        if (ACCESS_START && WAIT_ENABLE) begin
          ws_nxt = W_HOLD;
          wcnt_nxt = WAIT_CNT_LOAD;
          rdy_nxt = 1'b0;
        end
      end
      W_HOLD: begin
        rdy_nxt = 1'b0;
        wcnt_nxt = wcnt_r - 2'h1;
        // release after two clocks, the short end of the span
        if (wcnt_r == 2'h1) begin
          ws_nxt = W_DONE;
          rdy_nxt = 1'b1;
        end
      end
      W_DONE: begin
        rdy_nxt = 1'b1;
        wcnt_nxt = WAIT_CNT_ZERO;
        ws_nxt = W_IDLE;
      end
      // spare code falls back to idle with ready released
      default: begin
        ws_nxt = W_IDLE;
        wcnt_nxt = WAIT_CNT_ZERO;
        rdy_nxt = 1'b1;
      end
    endcase
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ws_r <= W_IDLE;
      wcnt_r <= WAIT_CNT_ZERO;
      rdy_r <= 1'b1;
    end else begin
      ws_r <= ws_nxt;
      wcnt_r <= wcnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign WIDE_MODE = wide_r;
  assign MEM_WIDE_SELECT_N = memcs_r;
  assign IO_WIDE_SELECT_N = iocs_r;
  assign IOCHRDY = rdy_r;
  assign LATCHED_ACCESS = lat_r;

  sequence s_wait_start;
    ACCESS_START && WAIT_ENABLE && ws_r == W_IDLE;
  endsequence
  sequence s_wait_low;
    !IOCHRDY [*2];
  endsequence

  // R01 low seen before write selects wide
  a_det_low_wide: assert property (@(posedge CLOCK) disable iff (!RSTN) // R01
    !det_s2_r && !cfg_written_r && !CFG_WRITE |=> WIDE_MODE)
    else $error("detect low did not select wide mode");
  // R02 no low keeps narrow
  a_det_high_narrow: assert property (@(posedge CLOCK) disable iff (!RSTN) // R02
    !cfg_written_r && !WIDE_MODE && det_s2_r && !CFG_WRITE |=> !WIDE_MODE)
    else $error("narrow mode left without low detect");
  // R04 write overrides
  a_cfg_override: assert property (@(posedge CLOCK) disable iff (!RSTN) // R04
    CFG_WRITE |=> WIDE_MODE == $past(CFG_WIDTH_IN))
    else $error("config write did not set width");
  a_cfg_sticks: assert property (@(posedge CLOCK) disable iff (!RSTN) // R04
    cfg_written_r && !CFG_WRITE |=> $stable(WIDE_MODE))
    else $error("width changed after config write");
  // R09 io select needs aen low
  a_io_aen: assert property (@(posedge CLOCK) disable iff (!RSTN) // R09
    aen_s2_r |=> IO_WIDE_SELECT_N)
    else $error("io wide select with aen high");
  // R07 mem select follows live address
  a_mem_decode: assert property (@(posedge CLOCK) disable iff (!RSTN) // R07
    (a_s2_r[MEM_HI:MEM_LO] == MEM_BASE) |=> !MEM_WIDE_SELECT_N)
    else $error("mem wide select missed");
  // R11 R13 latch on strobe edge
  a_latch_edge: assert property (@(posedge CLOCK) disable iff (!RSTN) // R11
    rd_d_r && !rd_s2_r |=> LATCHED_ACCESS.rd && LATCHED_ACCESS.addr == $past(a_s2_r))
    else $error("address not latched on read strobe");
  // R14 R15 exactly two clocks low, then ready back high
  a_wait_len: assert property (@(posedge CLOCK) disable iff (!RSTN) // R14
    s_wait_start |=> s_wait_low ##[0:1] IOCHRDY)
    else $error("ready negation length wrong");

  sequence s_wr_fall;
    wr_d_r && !wr_s2_r;
  endsequence
  sequence s_nowait_start;
    ACCESS_START && !WAIT_ENABLE && ws_r == W_IDLE;
  endsequence

  // R16 low seen stays sticky
  a_det_sticky: assert property (@(posedge CLOCK) disable iff (!RSTN) // R16
    wide_r && !cfg_written_r && !CFG_WRITE |=> WIDE_MODE)
    else $error("sticky wide default lost");
  // R04 write marks config written
  a_cfg_flag: assert property (@(posedge CLOCK) disable iff (!RSTN) // R04
    CFG_WRITE |=> cfg_written_r)
    else $error("config write not recorded");
  // R07 mem select released on mismatch
  a_mem_release: assert property (@(posedge CLOCK) disable iff (!RSTN) // R07
    (a_s2_r[MEM_HI:MEM_LO] != MEM_BASE) |=> MEM_WIDE_SELECT_N)
    else $error("mem wide select stuck");
  // R08 R09 io select on match
  a_io_decode: assert property (@(posedge CLOCK) disable iff (!RSTN) // R08
    ((a_s2_r[IO_HI:IO_LO] == IO_BASE) && !aen_s2_r) |=> !IO_WIDE_SELECT_N)
    else $error("io wide select missed");
  // R09 io select released on mismatch
  a_io_release: assert property (@(posedge CLOCK) disable iff (!RSTN) // R09
    (a_s2_r[IO_HI:IO_LO] != IO_BASE) |=> IO_WIDE_SELECT_N)
    else $error("io wide select stuck");
  // R11 R13 latch on write strobe edge
  a_latch_write: assert property (@(posedge CLOCK) disable iff (!RSTN) // R11
    s_wr_fall |=> LATCHED_ACCESS.wr && LATCHED_ACCESS.addr == $past(a_s2_r))
    else $error("address not latched on write strobe");
  // R10 latched copy holds between edges
  a_latch_hold: assert property (@(posedge CLOCK) disable iff (!RSTN) // R10
    !rd_fall && !wr_fall |=> $stable(LATCHED_ACCESS.addr)
      && !LATCHED_ACCESS.rd && !LATCHED_ACCESS.wr)
    else $error("latched address moved without strobe");
  // R11 latch taken with bale high
  a_latch_bale: assert property (@(posedge CLOCK) disable iff (!RSTN) // R11
    (rd_fall || wr_fall) && bale_s2_r |=> LATCHED_ACCESS.rd || LATCHED_ACCESS.wr)
    else $error("latch waited on bale");
  // R14 first wait cycle negates ready
  a_wait_first: assert property (@(posedge CLOCK) disable iff (!RSTN) // R14
    s_wait_start |=> !IOCHRDY && ws_r == W_HOLD)
    else $error("ready not negated at wait start");
  // R14 no negation with option off
  a_wait_off: assert property (@(posedge CLOCK) disable iff (!RSTN) // R14
    s_nowait_start |=> IOCHRDY)
    else $error("ready negated with wait option off");
  // R14 ready high while idle
  a_ready_idle: assert property (@(posedge CLOCK) disable iff (!RSTN) // R14
    ws_r == W_IDLE && !(ACCESS_START && WAIT_ENABLE) |=> IOCHRDY)
    else $error("ready low while idle");
  // R15 release then back to idle
  a_wait_done: assert property (@(posedge CLOCK) disable iff (!RSTN) // R15
    ws_r == W_DONE |=> ws_r == W_IDLE && IOCHRDY)
    else $error("wait timer did not return to idle");
endmodule : hbw_front

// File: logic/hbw_pkg.sv
// package for the host bus width and select front end
package hbw_pkg;
  localparam int MEM_AW = 20;
  localparam int IO_AW = 16;
  localparam int MEM_HI = 19;
  localparam int MEM_LO = 11;
  localparam int IO_HI = 15;
  localparam int IO_LO = 2;
  localparam logic [8:0] MEM_BASE_RST = 9'h0_1A0;
  localparam logic [13:0] IO_BASE_RST = 14'h00B8;
  localparam int CFG_WIDTH_BIT = 7;
  localparam int WAIT_XTAL_MIN = 2;
  localparam logic [1:0] WAIT_CNT_LOAD = 2'h2;
  localparam logic [1:0] WAIT_CNT_ZERO = 2'h0;
  typedef struct packed {
    logic [MEM_AW-1:0] addr;
    logic rd;
    logic wr;
  } hbw_mem_acc_t;
  typedef enum logic [1:0] {W_IDLE, W_HOLD, W_DONE} hbw_wait_t;
endpackage : hbw_pkg

// File: test/hbw_board_model.sv
// board-side model of the bus width detect pin
`timescale 1ns/1ps
module hbw_board_model (
  input wire logic bus16_present,
  output logic bus_width_detect_n
);
  // pull-up, ground contact
  // open pin settles at the pull-up level, never floats
  assign bus_width_detect_n = bus16_present ? 1'b0 : 1'b1;
endmodule : hbw_board_model

// File: test/tb.sv
// self-checking bench for the host bus front end
`timescale 1ns/1ps
module tb;
  import hbw_pkg::*;
  logic clk = 0, rstn = 0, b16 = 0, cw = 0, cwi = 0, we = 0, acs = 0, aen = 1;
  logic bale = 1, rd_n = 1, wr_n = 1;
  logic [MEM_AW-1:0] sa = 20'h0_0000;
  logic det_n, wide, msel_n, iosel_n, rdy;
  hbw_mem_acc_t lat;
  int error_cnt = 0, checked = 0;
  always #4 clk = ~clk;
  hbw_board_model u_board (.bus16_present(b16), .bus_width_detect_n(det_n));
  hbw_front DUT (
    .CLOCK(clk),
    .RSTN(rstn),
    .BUS_WIDTH_DETECT_N(det_n),
    .CFG_WRITE(cw),
    .CFG_WIDTH_IN(cwi),
    .WAIT_ENABLE(we),
    .ACCESS_START(acs),
    .SA(sa),
    .AEN(aen),
    .BALE(bale),
    .MEM_READ_STROBE_N(rd_n),
    .MEM_WRITE_STROBE_N(wr_n),
    .WIDE_MODE(wide),
    .MEM_WIDE_SELECT_N(msel_n),
    .IO_WIDE_SELECT_N(iosel_n),
    .IOCHRDY(rdy),
    .LATCHED_ACCESS(lat)
  );
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic chk1(input logic s, input logic e);
    chk({19'h0, s}, {19'h0, e});
  endtask : chk1
  // settle past the edge before sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic t_detect;
    step(6);
    chk1(wide, 1'b0);
    @(posedge clk) b16 <= 1;
    step(4);
    chk1(wide, 1'b1);
    @(posedge clk) b16 <= 0;
    step(4);
    chk1(wide, 1'b1);
    @(posedge clk) cw <= 1;
    @(posedge clk) begin
      cw <= 0;
      b16 <= 1;
    end
    step(6);
    chk1(wide, 1'b0);
    @(posedge clk) begin
      cw <= 1;
      cwi <= 1;
    end
    @(posedge clk) begin
      cw <= 0;
      b16 <= 0;
    end
    step(6);
    chk1(wide, 1'b1);
  endtask : t_detect
  // second hardware reset rearms the detector
  task automatic t_rearm;
    @(posedge clk) begin
      rstn <= 0;
      b16 <= 0;
    end
    step(2);
    chk1(wide, 1'b0);
    chk1(msel_n, 1'b1);
    chk1(iosel_n, 1'b1);
    chk1(rdy, 1'b1);
    chk(lat.addr, 20'h0_0000);
    @(posedge clk) rstn <= 1;
    step(6);
    chk1(wide, 1'b0);
    @(posedge clk) b16 <= 1;
    step(4);
    chk1(wide, 1'b1);
    @(posedge clk) b16 <= 0;
    step(1);
  endtask : t_rearm
  task automatic t_select;
    @(posedge clk) begin
      sa <= {MEM_BASE_RST, 11'h7F0};
      aen <= 0;
    end
    step(4);
    chk1(msel_n, 1'b0);
    @(posedge clk) sa <= {MEM_BASE_RST ^ 9'h001, 11'h000};
    step(4);
    chk1(msel_n, 1'b1);
    @(posedge clk) sa <= {4'h0, IO_BASE_RST, 2'h3};
    step(4);
    chk1(iosel_n, 1'b0);
    @(posedge clk) aen <= 1;
    step(4);
    chk1(iosel_n, 1'b1);
    @(posedge clk) begin
      aen <= 0;
      sa <= {4'h0, IO_BASE_RST ^ 14'h0001, 2'h0};
    end
    step(4);
    chk1(iosel_n, 1'b1);
  endtask : t_select
  // address goes bad while the strobe is still low
  task automatic t_split;
    logic [19:0] a;
    a = {MEM_BASE_RST, 11'h2A4};
    for (int h = 0; h < 2; h++) begin
      @(posedge clk) sa <= a ^ {19'h0, h[0]};
      step(3);
      @(posedge clk) begin
        rd_n <= h[0];
        wr_n <= !h[0];
      end
      step(3);
      chk1(lat.rd, !h[0]);
      chk1(lat.wr, h[0]);
      @(posedge clk) sa <= ~sa;
      step(3);
      @(posedge clk) begin
        rd_n <= 1;
        wr_n <= 1;
      end
      step(3);
      chk(lat.addr, a ^ {19'h0, h[0]});
    end
  endtask : t_split
  task automatic t_wait;
    int lows;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) begin
        we <= (k != 0);
        acs <= 1;
      end
      // second start while busy is refused
      @(posedge clk) acs <= (k == 2);
      lows = 0;
      repeat (6) begin
        #1;
        if (rdy === 1'b0) lows++;
        @(posedge clk);
        acs <= 0;
      end
      chk(20'(lows), (k != 0) ? 20'h0_0002 : 20'h0_0000);
    end
  endtask : t_wait
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    t_detect;
    t_select;
    t_rearm;
    t_split;
    t_wait;
    tally_and_finish;
  end
  // run is about 150 cycles, over sixteen times that is a hang
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish;
  end
endmodule : tb
